/* File: inc/axil_slave_map.svh */
// constants of the register-style slave port: codes, defaults and reset values
`ifndef AXIL_SLAVE_MAP_SVH
`define AXIL_SLAVE_MAP_SVH

// response codes driven on the write response and read data channels
`define AXIL_RESP_OKAY 2'h0
`define AXIL_RESP_SLVERR 2'h2
`define AXIL_RESP_DECERR 2'h3

// write strobe handling options
`define AXIL_STRB_HONOUR 2'h0
`define AXIL_STRB_IGNORE 2'h1
`define AXIL_STRB_CHECK 2'h2

// state codes, gray on each forward step; the return to the first state flips both bits
`define AXIL_WR_COLLECT 2'h0
`define AXIL_WR_COMMIT 2'h1
`define AXIL_WR_RESP 2'h3
`define AXIL_RD_ACCEPT 2'h0
`define AXIL_RD_LOAD 2'h1
`define AXIL_RD_DATA 2'h3

// build-time defaults
`define AXIL_NARROW_W 32
`define AXIL_WIDE_W 64
`define AXIL_ADDR_W_DEF 32
`define AXIL_ID_W_DEF 4
`define AXIL_DEPTH_LOG2_DEF 10
`define AXIL_PROT_W 3

// reset values and byte width
`define AXIL_RST_FLAG 1'h0
`define AXIL_BYTE_W 8

`endif

/* File: inc/axil_slave_pkg.sv */
// types shared by the register-style slave port
`include "axil_slave_map.svh"

package axil_slave_pkg;

	typedef enum logic [1:0] {
		RESP_OKAY = `AXIL_RESP_OKAY,
		RESP_SLVERR = `AXIL_RESP_SLVERR,
		RESP_DECERR = `AXIL_RESP_DECERR
	} resp_t;

	typedef enum logic [1:0] {
		WR_COLLECT = `AXIL_WR_COLLECT,
		WR_COMMIT = `AXIL_WR_COMMIT,
		WR_RESP = `AXIL_WR_RESP
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_ACCEPT = `AXIL_RD_ACCEPT,
		RD_LOAD = `AXIL_RD_LOAD,
		RD_DATA = `AXIL_RD_DATA
	} rd_state_t;

endpackage

/* File: verilog/byte_lane_mem.sv */
// one byte lane of the slave's storage: clocked write, direct read
`timescale 1ns/100ps
`include "axil_slave_map.svh"

module byte_lane_mem #(
	parameter int DEPTH_LOG2 = `AXIL_DEPTH_LOG2_DEF
) (
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [DEPTH_LOG2-1:0] wr_addr,
	input wire logic [`AXIL_BYTE_W-1:0] wr_byte,
	input wire logic [DEPTH_LOG2-1:0] rd_addr,
	output logic [`AXIL_BYTE_W-1:0] rd_byte
);

	logic [`AXIL_BYTE_W-1:0] store [2**DEPTH_LOG2];

	// contents carry no reset; only the enabled lane changes
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_byte;
		end
	end

	// read path is sampled into the caller's data register
	assign rd_byte = store[rd_addr];

endmodule // byte_lane_mem

/* File: verilog/axil_slave_port.sv */
// register-style single-beat bus slave port with byte-lane memory and id reflection
//
// Operation
// - every transfer is one beat, length one
// - data bus fixed at 32 or 64 bits
// - every access taken as full bus width
// - accesses non-modifiable, non-bufferable, cache ignored
// - normal accesses only, no exclusive sequences
// - exclusive-okay response is never returned
// - every data transfer is the last beat
// - port carries the lite signal set plus read and write ids
// - strobes honoured, ignored or checked by option
// - memory updates only lanes with strobe set, every lane when strobes are ignored
// - all-zero strobe writes accepted and answered
// - in-flight count limited only by ready signals
// - completion in address acceptance order within reads and within writes, not between the two
// - data of transactions never interleaved
// - wide port sees every access full width
// - accepted id returned with its response
// - write id taken from write address channel
// - byte-select address bits ignored, taken as zero
`timescale 1ns/100ps
`include "axil_slave_map.svh"

module axil_slave_port #(
	parameter bit WIDE_BUS = 1'b0,
	parameter int ADDR_W = `AXIL_ADDR_W_DEF,
	parameter int ID_W = `AXIL_ID_W_DEF,
	parameter int DEPTH_LOG2 = `AXIL_DEPTH_LOG2_DEF,
	parameter logic [1:0] STRB_MODE = `AXIL_STRB_HONOUR,
	localparam int DATA_W = WIDE_BUS ? `AXIL_WIDE_W : `AXIL_NARROW_W,
	localparam int LANES = DATA_W / `AXIL_BYTE_W
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [`AXIL_PROT_W-1:0] awprot,
	input wire logic [ID_W-1:0] awid,
	input wire logic wvalid,
	output logic wready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [LANES-1:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	output logic [ID_W-1:0] bid,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [`AXIL_PROT_W-1:0] arprot,
	input wire logic [ID_W-1:0] arid,
	output logic rvalid,
	input wire logic rready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic [ID_W-1:0] rid
);

	// the word index sits just above the byte-select bits; any set bit above
	// the storage span marks the access as a decode error
	localparam int LANE_BITS = $clog2(LANES);
	localparam int SPAN_BITS = LANE_BITS + DEPTH_LOG2;

	// write side state
	axil_slave_pkg::wr_state_t wr_state_q, wr_state_d;
	logic aw_held_q, aw_held_d;
	logic w_held_q, w_held_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic [DEPTH_LOG2-1:0] waddr_q;
	logic wbad_q;
	logic [DATA_W-1:0] wdata_q;
	logic [LANES-1:0] wstrb_q;
	logic [ID_W-1:0] bid_q;
	logic bvalid_q;
	axil_slave_pkg::resp_t bresp_q;
	axil_slave_pkg::resp_t wresp;
	logic aw_take, w_take;
	logic [LANES-1:0] lane_we;

	// read side state
	axil_slave_pkg::rd_state_t rd_state_q, rd_state_d;
	logic arready_q;
	logic [DEPTH_LOG2-1:0] raddr_q;
	logic rbad_q;
	logic [ID_W-1:0] rid_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	axil_slave_pkg::resp_t rresp_q;
	logic [DATA_W-1:0] lane_rd;
	logic ar_take;

	// handshakes: a channel transfer happens only on valid and our ready
	// readies come from flops, so no input reaches an output in the same cycle
	assign aw_take = awvalid && awready_q;
	assign w_take = wvalid && wready_q;
	assign ar_take = arvalid && arready_q;

	// write sequencing: gather address and data in any order, one write in flight
	// the held flags remember whichever channel arrived first; both clear once
	// the write leaves collection, so a stale half never pairs with the next one
	always_comb begin
		wr_state_d = wr_state_q;
		aw_held_d = aw_held_q || aw_take;
		w_held_d = w_held_q || w_take;
		unique case (wr_state_q)
			axil_slave_pkg::WR_COLLECT: begin
				if (aw_held_d && w_held_d) begin
					wr_state_d = axil_slave_pkg::WR_COMMIT;
				end
			end
			axil_slave_pkg::WR_COMMIT: begin
				wr_state_d = axil_slave_pkg::WR_RESP;
			end
			axil_slave_pkg::WR_RESP: begin
				if (bready) begin
					wr_state_d = axil_slave_pkg::WR_COLLECT;
				end
			end
		endcase
		if (wr_state_d != axil_slave_pkg::WR_COLLECT) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
		end
		// stalling by ready is the only throttle on the master
		awready_d = (wr_state_d == axil_slave_pkg::WR_COLLECT) && !aw_held_d;
		wready_d = (wr_state_d == axil_slave_pkg::WR_COLLECT) && !w_held_d;
	end

	// write state and handshake registers
	// readies reset low and rise on the first edge after release
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_state_q <= axil_slave_pkg::WR_COLLECT;
			aw_held_q <= `AXIL_RST_FLAG;
			w_held_q <= `AXIL_RST_FLAG;
			awready_q <= `AXIL_RST_FLAG;
			wready_q <= `AXIL_RST_FLAG;
		end else begin
			wr_state_q <= wr_state_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
		end
	end

	// write address capture; cache, lock and size are not on the port, prot is taken but unused
	// the byte-select bits are dropped here, the slave treats them as zero
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			waddr_q <= '0;
			wbad_q <= `AXIL_RST_FLAG;
			bid_q <= '0;
		end else if (aw_take) begin
			waddr_q <= awaddr[LANE_BITS +: DEPTH_LOG2];
			wbad_q <= |(awaddr >> SPAN_BITS);
			bid_q <= awid;
		end
	end

	// write data capture, whole bus in one transfer
	// data and strobes wait here for the commit cycle, so they may arrive first
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (w_take) begin
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
	end

	// response for the held write; never the exclusive-okay code
	// a decode error wins over a strobe error; neither touches the storage
	always_comb begin
		wresp = axil_slave_pkg::RESP_OKAY;
		if (wbad_q) begin
			wresp = axil_slave_pkg::RESP_DECERR;
		end else if (STRB_MODE == `AXIL_STRB_CHECK && wstrb_q != '0 && !(&wstrb_q)) begin
			wresp = axil_slave_pkg::RESP_SLVERR;
		end
	end

	// lane enables: strobe-selected, or every lane when strobes are ignored
	// a write with no strobes set still runs to a response; it writes nothing unless strobes are ignored
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			lane_we[i] = (wr_state_q == axil_slave_pkg::WR_COMMIT) &&
				(wresp == axil_slave_pkg::RESP_OKAY) &&
				((STRB_MODE == `AXIL_STRB_IGNORE) || wstrb_q[i]);
		end
	end

	// write response channel
	// the response stands until the master takes it; nothing new commits before
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bvalid_q <= `AXIL_RST_FLAG;
			bresp_q <= axil_slave_pkg::RESP_OKAY;
		end else if (wr_state_q == axil_slave_pkg::WR_COMMIT) begin
			bvalid_q <= 1'b1;
			bresp_q <= wresp;
		end else if (bvalid_q && bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read sequencing: one read in flight, data returned whole and in order
	// the load state gives the lanes one cycle to present the addressed word
	always_comb begin
		rd_state_d = rd_state_q;
		unique case (rd_state_q)
			axil_slave_pkg::RD_ACCEPT: begin
				if (ar_take) begin
					rd_state_d = axil_slave_pkg::RD_LOAD;
				end
			end
			axil_slave_pkg::RD_LOAD: begin
				rd_state_d = axil_slave_pkg::RD_DATA;
			end
			axil_slave_pkg::RD_DATA: begin
				if (rready) begin
					rd_state_d = axil_slave_pkg::RD_ACCEPT;
				end
			end
		endcase
	end

	// read state and address ready
	// the address ready drops for the whole read, the only throttle on the reader
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rd_state_q <= axil_slave_pkg::RD_ACCEPT;
			arready_q <= `AXIL_RST_FLAG;
		end else begin
			rd_state_q <= rd_state_d;
			arready_q <= (rd_state_d == axil_slave_pkg::RD_ACCEPT);
		end
	end

	// read address capture
	// the read id is kept so a full bus master can match the answer
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			raddr_q <= '0;
			rbad_q <= `AXIL_RST_FLAG;
			rid_q <= '0;
		end else if (ar_take) begin
			raddr_q <= araddr[LANE_BITS +: DEPTH_LOG2];
			rbad_q <= |(araddr >> SPAN_BITS);
			rid_q <= arid;
		end
	end

	// read data channel; decode errors return zero data
	// reads are not ordered against writes: a load in the commit cycle sees the old word
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rvalid_q <= `AXIL_RST_FLAG;
			rdata_q <= '0;
			rresp_q <= axil_slave_pkg::RESP_OKAY;
		end else if (rd_state_q == axil_slave_pkg::RD_LOAD) begin
			rvalid_q <= 1'b1;
			rdata_q <= rbad_q ? '0 : lane_rd;
			rresp_q <= rbad_q ? axil_slave_pkg::RESP_DECERR : axil_slave_pkg::RESP_OKAY;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// storage, one instance per byte lane
	// a separate write enable per lane is what lets narrow writes keep other bytes
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		byte_lane_mem #(
			.DEPTH_LOG2(DEPTH_LOG2)
		) u_lane (
			.ref_clk(ref_clk),
			.wr_en(lane_we[g]),
			.wr_addr(waddr_q),
			.wr_byte(wdata_q[`AXIL_BYTE_W*g +: `AXIL_BYTE_W]),
			.rd_addr(raddr_q),
			.rd_byte(lane_rd[`AXIL_BYTE_W*g +: `AXIL_BYTE_W])
		);
	end

	// outputs, all from flops
	// no output has a combinational path from any input
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign bid = bid_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign rid = rid_q;

endmodule // axil_slave_port

/* File: testbench/axil_slave_port_assertions.sv */
// concurrent checks on the slave port handshakes
`timescale 1ns/100ps
`include "axil_slave_map.svh"
module axil_slave_port_assertions #(
	parameter bit WIDE_BUS = 1'b0,
	parameter int ID_W = `AXIL_ID_W_DEF,
	localparam int DATA_W = WIDE_BUS ? `AXIL_WIDE_W : `AXIL_NARROW_W
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [ID_W-1:0] awid,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic [ID_W-1:0] bid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [ID_W-1:0] arid,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic [ID_W-1:0] rid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// the two ways a request is taken
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	// answer timing, holding and id reflection
	property p_b_late;
		s_wr_take |=> ##1 bvalid;
	endproperty
	a_b_late: assert property (p_b_late) else $error("write response late");
	property p_r_late;
		s_rd_take |=> ##1 rvalid;
	endproperty
	a_r_late: assert property (p_r_late) else $error("read data late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp) && $stable(bid);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rid);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_codes;
		(bvalid |-> bresp != 2'h1) and (rvalid |-> rresp != 2'h1);
	endproperty
	a_codes: assert property (p_codes) else $error("illegal response code");
	property p_one_wr;
		bvalid |-> !awready && !wready;
	endproperty
	a_one_wr: assert property (p_one_wr) else $error("write taken while busy");
	property p_ready_back;
		bvalid && bready |=> ##[0:1] (awready && wready);
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("write ready stuck");
	property p_rid;
		logic [ID_W-1:0] id;
		(s_rd_take, id = arid) |=> ##1 rid == id;
	endproperty
	a_rid: assert property (p_rid) else $error("read id not reflected");
	property p_bid;
		logic [ID_W-1:0] id;
		(s_wr_take, id = awid) |=> ##1 bid == id;
	endproperty
	a_bid: assert property (p_bid) else $error("write id not reflected");
endmodule // axil_slave_port_assertions

/* File: testbench/axil_master_model.sv */
// bus master that issues single-beat requests to the slave port
`timescale 1ns/100ps
module axil_master_model (
	input wire logic ref_clk,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] awaddr,
	output logic [2:0] awprot,
	output logic [3:0] awid,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	input wire logic [3:0] bid,
	output logic arvalid,
	input wire logic arready,
	output logic [31:0] araddr,
	output logic [2:0] arprot,
	output logic [3:0] arid,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic [3:0] rid,
	output logic hung
);
	// idle bus at time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, hung} = 6'h0;
		{awaddr, wdata, wstrb, awid, awprot} = '0;
		{araddr, arid, arprot} = '0;
	end
	// one write beat, response taken after sl stalled cycles
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s, id, input int sl,
		output logic [1:0] rs, output logic [3:0] ri);
		int n;
		@(posedge ref_clk);
		#1 {awaddr, wdata, wstrb, awid} = {a, d, s, id};
		awprot = 3'($urandom);
		{awvalid, wvalid} = 2'h3;
		n = 0;
		do @(posedge ref_clk); while (!(awready && wready) && ++n < 99);
		#1 {awvalid, wvalid} = 2'h0;
		{awaddr, wdata} = ~{awaddr, wdata}; // released lines stop showing old values
		repeat (sl) @(posedge ref_clk);
		#1 bready = 1;
		do @(posedge ref_clk); while (!bvalid && ++n < 99);
		{rs, ri} = {bresp, bid};
		#1 bready = 0;
		hung |= n >= 99;
	endtask
	// one read beat, data taken after sl stalled cycles
	task automatic rd(input logic [31:0] a, input logic [3:0] id, input int sl,
		output logic [31:0] d, output logic [1:0] rs, output logic [3:0] ri);
		int n;
		@(posedge ref_clk);
		#1 {araddr, arid, arprot} = {a, id, 3'($urandom)};
		arvalid = 1;
		n = 0;
		do @(posedge ref_clk); while (!arready && ++n < 99);
		#1 arvalid = 0;
		araddr = ~araddr;
		repeat (sl) @(posedge ref_clk);
		#1 rready = 1;
		do @(posedge ref_clk); while (!rvalid && ++n < 99);
		{d, rs, ri} = {rdata, rresp, rid};
		#1 rready = 0;
		hung |= n >= 99;
	endtask
endmodule // axil_master_model

/* File: testbench/axil_slave_port_tb_top.sv */
// self-checking bench for the slave port against a word model
`timescale 1ns/100ps
`include "axil_slave_map.svh"
module axil_slave_port_tb_top;
	logic ref_clk = 0;
	logic nrst = 0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, hung;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, araddr, wdata, rdata;
	logic [3:0] wstrb, awid, bid, arid, rid;
	logic [2:0] awprot, arprot;
	logic [1:0] bresp, rresp;
	logic [1:0] bresp_ign, rresp_ign, bresp_chk, rresp_chk;
	logic [31:0] rdata_ign, rdata_chk;
	int unsigned mem [16];
	int unsigned mem_ign [16];
	int unsigned mem_chk [16];
	int err_total = 0;
	int checks_done = 0;
	// 16-word memory keeps the decode boundary near
	axil_slave_port #(.DEPTH_LOG2(4)) DUT (.ref_clk, .nrst, .awvalid, .awready, .awaddr,
		.awprot, .awid, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .bid,
		.arvalid, .arready, .araddr, .arprot, .arid, .rvalid, .rready, .rdata, .rresp, .rid);
	axil_master_model M (.ref_clk, .awvalid, .awready, .awaddr, .awprot, .awid, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .bid, .arvalid, .arready, .araddr,
		.arprot, .arid, .rvalid, .rready, .rdata, .rresp, .rid, .hung);
	// the same stimulus drives a strobe-ignoring and a strobe-checking build in lockstep
	axil_slave_port #(.DEPTH_LOG2(4), .STRB_MODE(`AXIL_STRB_IGNORE)) DUT_IGN (
		.ref_clk, .nrst, .awvalid, .awready(), .awaddr, .awprot, .awid, .wvalid, .wready(),
		.wdata, .wstrb, .bvalid(), .bready, .bresp(bresp_ign), .bid(), .arvalid, .arready(),
		.araddr, .arprot, .arid, .rvalid(), .rready, .rdata(rdata_ign), .rresp(rresp_ign),
		.rid());
	axil_slave_port #(.DEPTH_LOG2(4), .STRB_MODE(`AXIL_STRB_CHECK)) DUT_CHK (
		.ref_clk, .nrst, .awvalid, .awready(), .awaddr, .awprot, .awid, .wvalid, .wready(),
		.wdata, .wstrb, .bvalid(), .bready, .bresp(bresp_chk), .bid(), .arvalid, .arready(),
		.araddr, .arprot, .arid, .rvalid(), .rready, .rdata(rdata_chk), .rresp(rresp_chk),
		.rid());
	always #5 ref_clk = ~ref_clk;
	// verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// write through the model, then update the reference words lane by lane, the strobe-ignoring copy whole
	task automatic w1(logic [31:0] a, d, logic [3:0] s, logic [1:0] er, int sl);
		logic [1:0] rs, ec;
		logic [3:0] id, ri;
		id = 4'($urandom);
		// the checking build refuses strobes that are neither full nor empty
		ec = (er == 2'h0 && s != 4'h0 && s != 4'hf) ? `AXIL_RESP_SLVERR : er;
		M.wr(a, d, s, id, sl, rs, ri);
		chk("bresp", {30'h0, er}, {30'h0, rs});
		chk("bid", {28'h0, id}, {28'h0, ri});
		chk("bresp_ign", {30'h0, er}, {30'h0, bresp_ign});
		chk("bresp_chk", {30'h0, ec}, {30'h0, bresp_chk});
		for (int i = 0; i < 4; i++) if (er == 0 && s[i]) mem[a[5:2]][8*i+:8] = d[8*i+:8];
		for (int i = 0; i < 4; i++) if (ec == 0 && s[i]) mem_chk[a[5:2]][8*i+:8] = d[8*i+:8];
		if (er == 0) mem_ign[a[5:2]] = d;
	endtask
	task automatic r1(logic [31:0] a, logic [1:0] er, int sl);
		logic [31:0] d;
		logic [1:0] rs;
		logic [3:0] id, ri;
		id = 4'($urandom);
		M.rd(a, id, sl, d, rs, ri);
		chk("rresp", {30'h0, er}, {30'h0, rs});
		chk("rid", {28'h0, id}, {28'h0, ri});
		chk("rdata", er ? 32'h0 : mem[a[5:2]], d);
		chk("rresp_ign", {30'h0, er}, {30'h0, rresp_ign});
		chk("rdata_ign", er ? 32'h0 : mem_ign[a[5:2]], rdata_ign);
		chk("rresp_chk", {30'h0, er}, {30'h0, rresp_chk});
		chk("rdata_chk", er ? 32'h0 : mem_chk[a[5:2]], rdata_chk);
	endtask
	always @(posedge hung) begin
		err_total++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h12c6));
		repeat (2) @(posedge ref_clk);
		#1 nrst = 1;
		for (int i = 0; i < 16; i++) w1(i * 4, $urandom, 4'hf, 2'h0, i % 3);
		$display("test fill done");
		for (int i = 0; i < 24; i++) w1($urandom % 64, $urandom, 4'(i % 8 ? $urandom : 0), 2'h0, 0);
		$display("test strobes done");
		for (int i = 0; i < 16; i++) r1(i * 4 + i % 4, 2'h0, i % 4);
		$display("test readback done");
		w1(32'h40 | $urandom % 64, $urandom, 4'hf, 2'h3, 1);
		r1(32'h100, 2'h3, 2);
		$display("test decode done");
		for (int i = 0; i < 8; i++) fork
			w1(i * 4, $urandom, 4'($urandom), 2'h0, i % 2);
			r1(i * 4 + 32, 2'h0, i % 3);
		join
		$display("test overlap done");
		complete_run();
	end
endmodule // axil_slave_port_tb_top
bind axil_slave_port axil_slave_port_assertions #(.WIDE_BUS(WIDE_BUS), .ID_W(ID_W)) chk (
	.ref_clk, .nrst, .awvalid, .awready, .awid, .wvalid, .wready, .bvalid, .bready, .bresp,
	.bid, .arvalid, .arready, .arid, .rvalid, .rready, .rdata, .rresp, .rid);
